/* hw/adc_seq_pkg.sv */
// Package: register map, field positions and encodings for the converter sequencer
package adc_seq_pkg;
   // Register byte addresses
   localparam logic [7:0] CTRL1_ADDR = 8'h00;
   localparam logic [7:0] CTRL2_ADDR = 8'h04;
   localparam logic [7:0] PINCFG_ADDR = 8'h08;
   localparam logic [7:0] RESULT_ADDR = 8'h0c;
   localparam logic [7:0] STATUS_ADDR = 8'h10;
   localparam logic [7:0] DMABUF_ADDR = 8'h14;
   // Control 1 field positions
   localparam int ON_BIT = 15;
   localparam int SIDL_BIT = 13;
   localparam int DMABM_BIT = 12;
   localparam int RES_BIT = 10;
   localparam int FORM_LSB = 8;
   localparam int TRIG_LSB = 5;
   localparam int SIM_BIT = 3;
   localparam int AUTO_SAMPLE_START_BIT = 2;
   localparam int SAMPLE_ENABLE_BIT = 1;
   localparam int DONE_BIT = 0;
   // Writable masks, unimplemented bits read zero
   localparam logic [15:0] CTRL1_MASK = 16'hb7ee;
   localparam logic [15:0] CTRL2_MASK = 16'h073c;
   localparam logic [15:0] CTRL1_RESET = 16'h0000;
   // Control 2 field positions
   localparam int SCAN_BIT = 10;
   localparam int CHPS_LSB = 8;
   localparam int SMPI_LSB = 2;
   // Trigger encodings
   localparam logic [2:0] TRIG_MANUAL = 3'h0;
   localparam logic [2:0] TRIG_EXTINT = 3'h1;
   localparam logic [2:0] TRIG_TMRA = 3'h2;
   localparam logic [2:0] TRIG_TMRB = 3'h4;
   localparam logic [2:0] TRIG_AUTO = 3'h7;
   // Result formats
   localparam logic [1:0] FMT_SFRAC = 2'h3;
   localparam logic [1:0] FMT_FRAC = 2'h2;
   localparam logic [1:0] FMT_SINT = 2'h1;
   localparam logic [1:0] FMT_INT = 2'h0;
   localparam int NUM_BUFS = 16;
   localparam logic [3:0] LAST_BUF = 4'hf;
   localparam int DMABL_W = 3;
endpackage

/* hw/adc_sequence_control.sv */
// Sequencer, control register and result formatting for a SAR converter
//
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Samples-per-interrupt count decides when complete flag sets; interrupt only if enabled.
// - With scanning on, scan list restarts at first entry on count reached.
// - Without DMA, results fill 16 buffers in turn; pointer wraps on count.
// - With DMA, single buffer overwritten per conversion; reader must keep up.
// - Done clears when conversion starts, sets at completion, holds through sampling.
// - Pin is digital input only when both modules configure it digital.
// - Module-on bit runs the converter; off holds it idle.
// - Stop-in-idle halts operation in Idle mode; clear continues.
// - Build mode set gives conversion-order addresses (from bufPtr, which stays 0 in a DMA build); clear gives scatter/gather addresses.
// - Resolution bit selects 12-bit single channel or 10-bit four channel.
// - 10-bit results formatted by four format codes.
// - 12-bit results use same codes with four trailing zeros for fractions.
// - Trigger field: counter, external edge, or software clear ends sampling.
// - Timer compare triggers: codes 010 and 100 pick the two timers.
// - Simultaneous sampling per channel count; bit reads zero in 12-bit mode.
// - Auto-sample restarts sampling after conversion and sets sample bit.
// - Code 000 software ends sampling; else hardware clears sample bit.
// - Software may clear done, writes of one ignored, conversion unaffected.
// - Count value N means event after every N+1 conversions.
// - Channel count: 00 ch0, 01 ch0-1, 1x ch0-3.
module adc_sequence_control #(
   parameter bit HAS_DMA = 1'b0
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic idleMode,
   input wire logic extIntEdge,
   input wire logic timer3Match,
   input wire logic timer5Match,
   input wire logic sampleTimeDone,
   input wire logic convDone,
   input wire logic [11:0] convData,
   input wire logic [4:0] inputIndex,
   input wire logic [2:0] dmaBufLen,
   input wire logic [15:0] otherPinCfg,
   input wire logic [15:0] pinRaw,
   input wire logic intEnable,
   output logic sampling,
   output logic convStart,
   output logic moduleRun,
   output logic twelveBit,
   output logic [1:0] activeChannels,
   output logic simSample,
   output logic scanRestart,
   output logic [3:0] bufPtr,
   output logic intFlag,
   output logic adcIrq,
   output logic dmaReq,
   output logic [15:0] dmaAddr,
   output logic [15:0] pinDigital
);
   localparam bit SECOND_MODULE = 1'b0; // Module 1 timer mapping
   logic rstMeta_ff, rstSync_ff;
   logic [15:0] ctrl1_ff;
   logic [15:0] ctrl2_ff;
   logic [15:0] pinCfg_ff;
   logic [15:0] result_ff [0:15];
   logic [3:0] bufPtr_ff;
   logic [3:0] smpCnt_ff;
   logic converting_ff;
   logic intFlag_ff;
   logic dmaReq_ff;
   logic scanRestart_ff;
   logic [15:0] dmaAddr_ff;
   logic [31:0] prdata_ff;
   logic [15:0] rdWord;
   logic wrEn, rdEn, endSample, countHit, running, trigOk, timerHit;
   logic [2:0] trig;
   logic [15:0] fmtWord;

   // ----------------------------------------------------------------
   // Reset synchroniser
   // ----------------------------------------------------------------
   // Release is delayed two clocks so all flops leave reset together
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rstMeta_ff <= 1'b0;
         rstSync_ff <= 1'b0;
      end else begin
         rstMeta_ff <= 1'b1;
         rstSync_ff <= rstMeta_ff;
      end
   end

   // Formats a raw sample per resolution and format code
   function automatic logic [15:0] format_result(input logic [11:0] d, input logic b12, input logic [1:0] f);
      logic [15:0] r;
      r = 16'h0000;
      if (b12) begin
         unique case (f)
            adc_seq_pkg::FMT_SFRAC: r = {~d[11], d[10:0], 4'h0};
            adc_seq_pkg::FMT_FRAC: r = {d[11:0], 4'h0};
            adc_seq_pkg::FMT_SINT: r = {{5{~d[11]}}, d[10:0]};
            adc_seq_pkg::FMT_INT: r = {4'h0, d[11:0]};
         endcase
      end else begin
         unique case (f)
            adc_seq_pkg::FMT_SFRAC: r = {~d[9], d[8:0], 6'h00};
            adc_seq_pkg::FMT_FRAC: r = {d[9:0], 6'h00};
            adc_seq_pkg::FMT_SINT: r = {{7{~d[9]}}, d[8:0]};
            adc_seq_pkg::FMT_INT: r = {6'h00, d[9:0]};
         endcase
      end
      return r;
   endfunction

   // ----------------------------------------------------------------
   // Bus decode and sequencing terms
   // ----------------------------------------------------------------
   // Zero-wait slave: every access completes in its first access cycle
   assign pready = 1'b1;
   assign wrEn = psel & penable & pwrite;
   assign rdEn = psel & penable & ~pwrite;
   assign pslverr = psel & penable & (paddr > adc_seq_pkg::DMABUF_ADDR);
   assign trig = ctrl1_ff[adc_seq_pkg::TRIG_LSB +: 3];
   assign twelveBit = ctrl1_ff[adc_seq_pkg::RES_BIT];
   assign running = ctrl1_ff[adc_seq_pkg::ON_BIT]
                    & ~(ctrl1_ff[adc_seq_pkg::SIDL_BIT] & idleMode);
   assign moduleRun = running;
   // Timer pair swaps between modules
   assign timerHit = (trig == adc_seq_pkg::TRIG_TMRA) ? (SECOND_MODULE ? timer5Match : timer3Match)
                     : (SECOND_MODULE ? timer3Match : timer5Match);
   // Reserved codes never end sampling
   always_comb begin
      unique case (trig)
         adc_seq_pkg::TRIG_AUTO: trigOk = sampleTimeDone;
         adc_seq_pkg::TRIG_EXTINT: trigOk = extIntEdge;
         adc_seq_pkg::TRIG_TMRA, adc_seq_pkg::TRIG_TMRB: trigOk = timerHit;
         default: trigOk = 1'b0;
      endcase
   end
   // Software ending of manual sampling: sample bit written low while set
   assign endSample = running & ctrl1_ff[adc_seq_pkg::SAMPLE_ENABLE_BIT] & ~converting_ff
                      & ((trig == adc_seq_pkg::TRIG_MANUAL)
                         ? (wrEn & (paddr == adc_seq_pkg::CTRL1_ADDR) & ~pwdata[adc_seq_pkg::SAMPLE_ENABLE_BIT])
                         : trigOk);
   assign convStart = endSample;
   assign sampling = ctrl1_ff[adc_seq_pkg::SAMPLE_ENABLE_BIT];
   assign countHit = running & converting_ff & convDone
                     & (smpCnt_ff == ctrl2_ff[adc_seq_pkg::SMPI_LSB +: 4]);
   // Channel count collapses to one in 12-bit mode
   assign activeChannels = twelveBit ? 2'h0
                           : (ctrl2_ff[adc_seq_pkg::CHPS_LSB + 1] ? 2'h3
                              : {1'b0, ctrl2_ff[adc_seq_pkg::CHPS_LSB]});
   assign simSample = ctrl1_ff[adc_seq_pkg::SIM_BIT] & (activeChannels != 2'h0);
   assign fmtWord = format_result(convData, twelveBit, ctrl1_ff[adc_seq_pkg::FORM_LSB +: 2]);

   // ----------------------------------------------------------------
   // Control register 1
   // ----------------------------------------------------------------
   // Hardware set of done wins over a software clear in the same cycle
   always_ff @(posedge clk or negedge rstSync_ff) begin
      if (!rstSync_ff) begin
         ctrl1_ff <= adc_seq_pkg::CTRL1_RESET;
      end else begin
         if (wrEn && paddr == adc_seq_pkg::CTRL1_ADDR) begin
            ctrl1_ff[15:2] <= pwdata[15:2] & adc_seq_pkg::CTRL1_MASK[15:2];
            // Sample bit set only by software when auto-start is off
            if (pwdata[adc_seq_pkg::SAMPLE_ENABLE_BIT] && !pwdata[adc_seq_pkg::AUTO_SAMPLE_START_BIT]) begin
               ctrl1_ff[adc_seq_pkg::SAMPLE_ENABLE_BIT] <= 1'b1;
            end
            if (!pwdata[adc_seq_pkg::DONE_BIT]) begin
               ctrl1_ff[adc_seq_pkg::DONE_BIT] <= 1'b0;
            end
            if (pwdata[adc_seq_pkg::RES_BIT]) begin
               ctrl1_ff[adc_seq_pkg::SIM_BIT] <= 1'b0;
            end
         end
         if (endSample) begin
            ctrl1_ff[adc_seq_pkg::SAMPLE_ENABLE_BIT] <= 1'b0;
            ctrl1_ff[adc_seq_pkg::DONE_BIT] <= 1'b0;
         end
         if (running && converting_ff && convDone) begin
            ctrl1_ff[adc_seq_pkg::DONE_BIT] <= 1'b1;
            ctrl1_ff[adc_seq_pkg::SAMPLE_ENABLE_BIT] <= ctrl1_ff[adc_seq_pkg::AUTO_SAMPLE_START_BIT];
         end
      end
   end

   // ----------------------------------------------------------------
   // Other software registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rstSync_ff) begin
      if (!rstSync_ff) begin
         ctrl2_ff <= 16'h0000;
         pinCfg_ff <= 16'h0000;
      end else if (wrEn) begin
         if (paddr == adc_seq_pkg::CTRL2_ADDR) begin
            ctrl2_ff <= pwdata[15:0] & adc_seq_pkg::CTRL2_MASK;
         end
         if (paddr == adc_seq_pkg::PINCFG_ADDR) begin
            pinCfg_ff <= pwdata[15:0];
         end
      end
   end
   // Digital buffer only enabled when both modules agree
   assign pinDigital = pinCfg_ff & otherPinCfg & pinRaw;

   // ----------------------------------------------------------------
   // Conversion tracking and sample counter
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rstSync_ff) begin
      if (!rstSync_ff) begin
         converting_ff <= 1'b0;
         smpCnt_ff <= 4'h0;
      end else begin
         if (!running) begin
            converting_ff <= 1'b0;
         end else if (endSample) begin
            converting_ff <= 1'b1;
         end else if (convDone) begin
            converting_ff <= 1'b0;
         end
         if (countHit) begin
            smpCnt_ff <= 4'h0;
         end else if (running && converting_ff && convDone) begin
            smpCnt_ff <= smpCnt_ff + 4'h1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Result storage and pointer
   // ----------------------------------------------------------------
   // A DMA build keeps one word that every conversion overwrites
   always_ff @(posedge clk or negedge rstSync_ff) begin
      if (!rstSync_ff) begin
         bufPtr_ff <= 4'h0;
         for (int i = 0; i < adc_seq_pkg::NUM_BUFS; i++) begin
            result_ff[i] <= 16'h0000;
         end
      end else if (running && converting_ff && convDone) begin
         if (HAS_DMA) begin
            result_ff[0] <= fmtWord;
         end else begin
            result_ff[bufPtr_ff] <= fmtWord;
            bufPtr_ff <= (countHit || bufPtr_ff == adc_seq_pkg::LAST_BUF) ? 4'h0 : bufPtr_ff + 4'h1;
         end
      end
   end
   assign bufPtr = bufPtr_ff;

   // ----------------------------------------------------------------
   // Completion events, scan restart and DMA address
   // ----------------------------------------------------------------
   // Flag is sticky; a software clear loses to a same-cycle event
   always_ff @(posedge clk or negedge rstSync_ff) begin
      if (!rstSync_ff) begin
         intFlag_ff <= 1'b0;
         dmaReq_ff <= 1'b0;
         scanRestart_ff <= 1'b0;
         dmaAddr_ff <= 16'h0000;
      end else begin
         dmaReq_ff <= countHit;
         scanRestart_ff <= countHit & ctrl2_ff[adc_seq_pkg::SCAN_BIT];
         if (countHit) begin
            intFlag_ff <= 1'b1;
         end else if (wrEn && paddr == adc_seq_pkg::STATUS_ADDR && pwdata[0]) begin
            intFlag_ff <= 1'b0;
         end
         if (running && converting_ff && convDone) begin
            if (ctrl1_ff[adc_seq_pkg::DMABM_BIT]) begin
               dmaAddr_ff <= {12'h000, bufPtr_ff};
            end else begin
               dmaAddr_ff <= 16'((32'(inputIndex) << dmaBufLen) + 32'(smpCnt_ff & ((4'h1 << dmaBufLen) - 4'h1)));
            end
         end
      end
   end
   assign intFlag = intFlag_ff;
   assign adcIrq = intFlag_ff & intEnable;
   assign dmaReq = dmaReq_ff;
   assign scanRestart = scanRestart_ff;
   assign dmaAddr = dmaAddr_ff;

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   always_comb begin
      rdWord = 16'h0000;
      unique case (paddr)
         adc_seq_pkg::CTRL1_ADDR: rdWord = ctrl1_ff;
         adc_seq_pkg::CTRL2_ADDR: rdWord = ctrl2_ff;
         adc_seq_pkg::PINCFG_ADDR: rdWord = pinCfg_ff;
         adc_seq_pkg::RESULT_ADDR: rdWord = HAS_DMA ? result_ff[0] : result_ff[paddr[5:2] - paddr[5:2]];
         adc_seq_pkg::STATUS_ADDR: rdWord = {7'h00, converting_ff, smpCnt_ff, bufPtr_ff};
         adc_seq_pkg::DMABUF_ADDR: rdWord = dmaAddr_ff;
         default: rdWord = 16'h0000;
      endcase
   end
   always_ff @(posedge clk or negedge rstSync_ff) begin
      if (!rstSync_ff) begin
         prdata_ff <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata_ff <= {16'h0000, rdWord};
      end
   end
   assign prdata = prdata_ff;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_done_on_complete: assert property (@(posedge clk) disable iff (!rstSync_ff)
      (running && converting_ff && convDone) |=> ctrl1_ff[adc_seq_pkg::DONE_BIT]) else $error("done not set");
   a_done_clear_start: assert property (@(posedge clk) disable iff (!rstSync_ff)
      (endSample && !convDone) |=> !ctrl1_ff[adc_seq_pkg::DONE_BIT]) else $error("done not cleared");
   a_sample_enable_auto_end: assert property (@(posedge clk) disable iff (!rstSync_ff)
      endSample |=> !ctrl1_ff[adc_seq_pkg::SAMPLE_ENABLE_BIT]) else $error("sample not ended");
   a_reserved_trig: assert property (@(posedge clk) disable iff (!rstSync_ff)
      (trig == 3'h3 || trig == 3'h5 || trig == 3'h6) |-> !endSample) else $error("reserved trigger started");
   a_irq_gate: assert property (@(posedge clk) disable iff (!rstSync_ff)
      countHit |=> intFlag && (adcIrq == intEnable)) else $error("interrupt flag missing");
   a_off_no_start: assert property (@(posedge clk) disable iff (!rstSync_ff)
      !ctrl1_ff[adc_seq_pkg::ON_BIT] |-> !convStart) else $error("start while off");
   a_idle_halt: assert property (@(posedge clk) disable iff (!rstSync_ff)
      (ctrl1_ff[adc_seq_pkg::SIDL_BIT] && idleMode) |-> !moduleRun) else $error("runs in idle");
   a_ptr_wrap: assert property (@(posedge clk) disable iff (!rstSync_ff)
      (countHit && !HAS_DMA) |=> bufPtr == 4'h0) else $error("pointer not reset");
   a_scan_restart: assert property (@(posedge clk) disable iff (!rstSync_ff)
      (countHit && ctrl2_ff[adc_seq_pkg::SCAN_BIT]) |=> scanRestart) else $error("scan not restarted");
   a_pin_digital: assert property (@(posedge clk) disable iff (!rstSync_ff)
      (pinDigital & ~(pinCfg_ff & otherPinCfg)) == 16'h0000) else $error("pin gating wrong");
   a_sim_12bit: assert property (@(posedge clk) disable iff (!rstSync_ff)
      twelveBit |-> !simSample) else $error("simultaneous in 12-bit");
endmodule
`default_nettype wire

/* sim/sar_core_model.sv */
// Behavioural model of the analog SAR core facing the sequencer
`timescale 1ns/1ps
`default_nettype none
module sar_core_model #(
   parameter int LAT = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic convStart,
   input wire logic [11:0] nextData,
   output logic convDone,
   output logic [11:0] convData
);
   int cnt;
   logic [11:0] last;
   // ----------------------------------------
   // Conversion timer
   // ----------------------------------------
   // One conversion at a time; data is shown for the done cycle only, then inverted
   // so a late reader never sees a stale match
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= 0;
         convDone <= 1'b0;
         convData <= 12'h000;
         last <= 12'h000;
      end else begin
         convDone <= 1'b0;
         convData <= ~last;
         if (convStart) begin
            cnt <= LAT;
         end else if (cnt > 1) begin
            cnt <= cnt - 1;
         end else if (cnt == 1) begin
            cnt <= 0;
            convDone <= 1'b1; // Result must be taken this cycle
            convData <= nextData;
            last <= nextData;
         end
      end
   end
endmodule
`default_nettype wire

/* sim/tb_adc_sequence_control.sv */
// Self-checking testbench for the converter sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_adc_sequence_control;
   logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, idleMode = 1'b0, intEnable = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [3:0] trg = 4'h0;
   logic [11:0] nextData = 12'h000, convData;
   logic [15:0] pinCfgOther = 16'h0f0f, pinRaw = 16'h3333, pinDigital, dmaAddr;
   logic pready, pslverr, err, sampling, convStart, moduleRun, twelveBit, simSample, scanRestart, intFlag, adcIrq;
   logic convDone, dmaReq;
   logic [1:0] activeChannels;
   logic [3:0] bufPtr;
   int n_errors = 0, check_count = 0, nStart = 0, nScan = 0, nDma = 0, cyc = 0;
   localparam logic [15:0] ON = 16'h0001 << adc_seq_pkg::ON_BIT;
   localparam logic [15:0] SAMPLE_ENABLE = 16'h0002;
   localparam logic [15:0] AUTO_SAMPLE_START = 16'h0004;
   always #50 clk = ~clk;
   adc_sequence_control i_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .idleMode(idleMode),
      .extIntEdge(trg[0]), .timer3Match(trg[1]), .timer5Match(trg[2]), .sampleTimeDone(trg[3]),
      .convDone(convDone), .convData(convData), .inputIndex(5'h03), .dmaBufLen(3'h1), .otherPinCfg(pinCfgOther),
      .pinRaw(pinRaw), .intEnable(intEnable), .sampling(sampling), .convStart(convStart), .moduleRun(moduleRun),
      .twelveBit(twelveBit), .activeChannels(activeChannels), .simSample(simSample), .scanRestart(scanRestart),
      .bufPtr(bufPtr), .intFlag(intFlag), .adcIrq(adcIrq), .dmaReq(dmaReq), .dmaAddr(dmaAddr),
      .pinDigital(pinDigital));
   sar_core_model i_core (.clk(clk), .rst_n(rst_n), .convStart(convStart), .nextData(nextData),
      .convDone(convDone), .convData(convData));
   // ----------------------------------------
   // Event counters and watchdog
   // ----------------------------------------
   // Pulses are counted at the edge so one-cycle strobes are never missed
   always @(posedge clk) begin
      nStart += (convStart === 1'b1);
      nScan += (scanRestart === 1'b1);
      nDma += (dmaReq === 1'b1);
      cyc++;
      if (cyc > 20000) begin
         n_errors++;
         end_sim();
      end
   end
   task automatic end_sim;
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chkReg(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chkBit(input logic got, input logic exp);
      chkReg({31'h0, got}, {31'h0, exp});
   endtask
   // Held request until pready is seen high at an edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // One more edge so checks after the call see the written state settled
      @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      apb(1'b1, a, {16'h0, d});
   endtask
   task automatic rdChk(input logic [7:0] a, input logic [15:0] exp);
      apb(1'b0, a, 32'h0);
      chkReg(rd, {16'h0, exp});
   endtask
   task automatic pulse(input int i);
      @(posedge clk);
      trg[i] <= 1'b1;
      @(posedge clk);
      trg[i] <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
   task automatic wait_done;
      int k;
      k = 0;
      while (convDone !== 1'b1 && k < 40) begin
         @(posedge clk);
         k++;
      end
      chkBit(convDone, 1'b1);
      repeat (2) @(posedge clk);
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset;
      rdChk(adc_seq_pkg::CTRL1_ADDR, adc_seq_pkg::CTRL1_RESET);
      rdChk(adc_seq_pkg::CTRL2_ADDR, 16'h0000);
      rdChk(8'h18, 16'h0000);
      chkBit(err, 1'b1);
      $display("test reset done");
   endtask
   task automatic t_manual;
      wr(adc_seq_pkg::CTRL1_ADDR, ON | SAMPLE_ENABLE);
      chkBit(sampling, 1'b1);
      nextData <= 12'h5a5;
      wr(adc_seq_pkg::CTRL1_ADDR, ON);
      rdChk(adc_seq_pkg::CTRL1_ADDR, ON);
      wait_done();
      rdChk(adc_seq_pkg::CTRL1_ADDR, ON | 16'h1);
      wr(adc_seq_pkg::CTRL1_ADDR, ON | SAMPLE_ENABLE | 16'h1);
      rdChk(adc_seq_pkg::CTRL1_ADDR, ON | SAMPLE_ENABLE | 16'h1);
      wr(adc_seq_pkg::CTRL1_ADDR, ON | SAMPLE_ENABLE);
      rdChk(adc_seq_pkg::CTRL1_ADDR, ON | SAMPLE_ENABLE);
      wr(adc_seq_pkg::CTRL1_ADDR, ON | SAMPLE_ENABLE | 16'h1);
      rdChk(adc_seq_pkg::CTRL1_ADDR, ON | SAMPLE_ENABLE);
      wr(adc_seq_pkg::CTRL1_ADDR, ON);
      wait_done();
      $display("test manual done");
   endtask
   task automatic t_format;
      logic [11:0] d;
      logic [15:0] e, c;
      d = 12'h6b3;
      for (int r = 0; r < 2; r++) begin
         for (int f = 0; f < 4; f++) begin
            c = ON | (16'(r) << adc_seq_pkg::RES_BIT) | (16'(f) << adc_seq_pkg::FORM_LSB);
            if (r == 0) begin
               e = f == 0 ? {6'h0, d[9:0]} : f == 1 ? {{7{~d[9]}}, d[8:0]} :
                   f == 2 ? {d[9:0], 6'h0} : {~d[9], d[8:0], 6'h0};
            end else begin
               e = f == 0 ? {4'h0, d} : f == 1 ? {{5{~d[11]}}, d[10:0]} :
                   f == 2 ? {d, 4'h0} : {~d[11], d[10:0], 4'h0};
            end
            // Polling software clears done first, then raises the sample bit
            wr(adc_seq_pkg::CTRL1_ADDR, c);
            wr(adc_seq_pkg::CTRL1_ADDR, c | SAMPLE_ENABLE);
            nextData <= d;
            wr(adc_seq_pkg::CTRL1_ADDR, c);
            wait_done();
            rdChk(adc_seq_pkg::RESULT_ADDR, e);
            chkBit(twelveBit, r[0]);
         end
      end
      $display("test format done");
   endtask
   task automatic t_trig;
      int codes[4] = '{1, 2, 4, 7};
      int good[4] = '{0, 1, 2, 3};
      int bad[4] = '{1, 2, 1, 0};
      int rsv[3] = '{3, 5, 6};
      int s;
      for (int i = 0; i < 4; i++) begin
         wr(adc_seq_pkg::CTRL1_ADDR, ON | SAMPLE_ENABLE | (16'(codes[i]) << adc_seq_pkg::TRIG_LSB));
         s = nStart;
         pulse(bad[i]);
         chkReg(nStart, s);
         pulse(good[i]);
         wait_done();
         chkReg(nStart, s + 1);
         chkBit(sampling, 1'b0);
      end
      for (int i = 0; i < 3; i++) begin
         wr(adc_seq_pkg::CTRL1_ADDR, ON | SAMPLE_ENABLE | (16'(rsv[i]) << adc_seq_pkg::TRIG_LSB));
         s = nStart;
         for (int j = 0; j < 4; j++) pulse(j);
         chkReg(nStart, s);
         chkBit(sampling, 1'b1);
      end
      $display("test trigger done");
   endtask
   task automatic t_count;
      logic [15:0] c;
      int sD;
      c = ON | (16'h7 << adc_seq_pkg::TRIG_LSB);
      // Earlier one-per-interrupt runs left the sticky flag set
      wr(adc_seq_pkg::STATUS_ADDR, 16'h0001);
      chkBit(intFlag, 1'b0);
      sD = nDma;
      wr(adc_seq_pkg::CTRL2_ADDR, 16'h0408);
      wr(adc_seq_pkg::CTRL1_ADDR, c | SAMPLE_ENABLE);
      wr(adc_seq_pkg::CTRL1_ADDR, c | AUTO_SAMPLE_START | SAMPLE_ENABLE);
      intEnable <= 1'b1;
      for (int i = 1; i <= 3; i++) begin
         pulse(3);
         wait_done();
         chkBit(sampling, 1'b1);
         chkBit(intFlag, i == 3);
         chkReg(bufPtr, i % 3);
         // Input 3 with two words per input: base 6, offset alternates
         chkReg(dmaAddr, 6 + (i - 1) % 2);
      end
      chkBit(adcIrq, 1'b1);
      chkReg(nScan, 1);
      chkReg(nDma, sD + 1);
      wr(adc_seq_pkg::STATUS_ADDR, 16'h0001);
      chkBit(intFlag, 1'b0);
      $display("test count done");
   endtask
   task automatic t_misc;
      wr(adc_seq_pkg::PINCFG_ADDR, 16'h00ff);
      chkReg(pinDigital, 16'h0003);
      wr(adc_seq_pkg::CTRL1_ADDR, 16'h0000);
      chkBit(moduleRun, 1'b0);
      idleMode <= 1'b1;
      wr(adc_seq_pkg::CTRL1_ADDR, ON | 16'h2000);
      chkBit(moduleRun, 1'b0);
      wr(adc_seq_pkg::CTRL1_ADDR, ON | 16'h0008);
      chkBit(moduleRun, 1'b1);
      wr(adc_seq_pkg::CTRL2_ADDR, 16'h0100);
      chkReg(activeChannels, 1);
      chkBit(simSample, 1'b1);
      wr(adc_seq_pkg::CTRL2_ADDR, 16'h0200);
      chkReg(activeChannels, 3);
      wr(adc_seq_pkg::CTRL1_ADDR, ON | 16'h0408);
      rdChk(adc_seq_pkg::CTRL1_ADDR, ON | 16'h0400);
      chkReg(activeChannels, 0);
      chkBit(simSample, 1'b0);
      $display("test misc done");
   endtask
   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      t_reset();
      t_manual();
      t_format();
      t_trig();
      t_count();
      t_misc();
      end_sim();
   end
endmodule
`default_nettype wire
